// [crcsp_pkg.sv]
// Package for the spare scratch, section 2 CRC reference and test DAC B configuration registers.
// Assumes an 8-bit register address and 16-bit register words from the host register port.
package crcsp_pkg;

  localparam int CRCSP_ADDR_W = 8;
  localparam int CRCSP_DATA_W = 16;

  // Register addresses.
  localparam logic [7:0] CRCSP_ADDR_SPARE_A = 8'ha1;
  localparam logic [7:0] CRCSP_ADDR_SPARE_B = 8'ha2;
  localparam logic [7:0] CRCSP_ADDR_SPARE_C = 8'ha3;
  localparam logic [7:0] CRCSP_ADDR_S2_REF = 8'hbe;
  localparam logic [7:0] CRCSP_ADDR_S3_CFG = 8'hc0;

  // Section 3 coverage range.
  localparam logic [7:0] CRCSP_S3_FIRST = 8'hc0;
  localparam logic [7:0] CRCSP_S3_LAST = 8'he3;

  // Writable masks and reset values.
  localparam logic [15:0] CRCSP_MASK_FULL = 16'hffff;
  localparam logic [15:0] CRCSP_MASK_SPARE_B = 16'hff00;
  localparam logic [15:0] CRCSP_MASK_S3_CFG = 16'h8007;
  localparam logic [15:0] CRCSP_RESET_VALUE = 16'h0000;

  // Field positions in the section 3 configuration register.
  localparam int CRCSP_S3_EN_BIT = 15;
  localparam int CRCSP_TDAC_MSB = 2;
  localparam int CRCSP_TDAC_LSB = 0;

  // Test DAC B level codes, multiples of reference_b_voltage / 40.
  typedef enum logic [2:0] {
    CRCSP_TDAC_X1 = 3'h0,
    CRCSP_TDAC_X2 = 3'h1,
    CRCSP_TDAC_X4 = 3'h2,
    CRCSP_TDAC_U3 = 3'h3,
    CRCSP_TDAC_X18 = 3'h4,
    CRCSP_TDAC_U5 = 3'h5,
    CRCSP_TDAC_NEG4 = 3'h6,
    CRCSP_TDAC_NEG9 = 3'h7
  } crcsp_tdac_type;

endpackage : crcsp_pkg

// [crcsp_reg16.sv]
// One 16-bit register with a writable-bit mask; masked bits always read as zero.
// Assumes a write strobe synchronous to ref_clk_in.
`timescale 1ns/1ps
module crcsp_reg16
  import crcsp_pkg::*;
#(
  parameter logic [15:0] WRITE_MASK = CRCSP_MASK_FULL
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic wr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] value_out
);

  // Only writable positions take new data, so reserved bits stay at their fixed zero.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= CRCSP_RESET_VALUE;
    end else if (clk_en_in && wr_in) begin
      value_out <= wdata_in & WRITE_MASK;
    end
  end

endmodule : crcsp_reg16

// [crcsp_regs.sv]
// Register bank: three spare scratch registers, section 2 CRC reference and
// section 3 CRC enable with test DAC B level. Assumes a host register port with
// one-cycle write and read strobes, synchronous to ref_clk_in.
// Assumes the CRC engines and the test DAC sit outside and only read the
// registered copies on the output ports; they never write back into the bank.
// A clock enable held low freezes every flip-flop here, the read answer included.
// Reserved positions are forced to zero at storage, so the read path needs no masks.
`timescale 1ns/1ps
module crcsp_regs
  import crcsp_pkg::*;
#(
  parameter int ADDR_W = CRCSP_ADDR_W,
  parameter int DATA_W = CRCSP_DATA_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic reg_hit_out,
  output logic [15:0] spare_scratch_a_out,
  output logic [15:0] spare_scratch_b_out,
  output logic [15:0] spare_scratch_c_out,
  output logic [15:0] section2_crc_reference_value_out,
  output logic section3_crc_enable_out,
  output logic [2:0] test_dac_b_level_out,
  output logic test_dac_b_negative_out
);

  // Stored register words; reserved positions are already zero inside each register.
  logic [15:0] spare_a;
  logic [15:0] spare_b;
  logic [15:0] spare_c;
  logic [15:0] s2_ref;
  logic [15:0] s3_cfg;
  // Per-register write strobes decoded from the shared address.
  logic wr_spare_a;
  logic wr_spare_b;
  logic wr_spare_c;
  logic wr_s2_ref;
  logic wr_s3_cfg;
  // Read mux and level decode results ahead of their flip-flops.
  logic [15:0] next_rdata;
  logic next_hit;
  logic next_dac_negative;
  crcsp_tdac_type tdac_code;

  // The decode and the masks are built for 8-bit addresses and 16-bit words,
  // so any other width is refused when the design is elaborated.
  if (ADDR_W != CRCSP_ADDR_W) begin : g_bad_addr_w
    $error("crcsp_regs supports only 8-bit register addresses");
  end
  if (DATA_W != CRCSP_DATA_W) begin : g_bad_data_w
    $error("crcsp_regs supports only 16-bit register words");
  end

  // unmapped writes dropped.
  // Each register sees its own strobe and an address outside the bank strobes
  // nothing, so a stray write can never land in a neighbouring register.
  assign wr_spare_a = reg_wr_in && (reg_addr_in == CRCSP_ADDR_SPARE_A);
  assign wr_spare_b = reg_wr_in && (reg_addr_in == CRCSP_ADDR_SPARE_B);
  assign wr_spare_c = reg_wr_in && (reg_addr_in == CRCSP_ADDR_SPARE_C);
  assign wr_s2_ref = reg_wr_in && (reg_addr_in == CRCSP_ADDR_S2_REF);
  assign wr_s3_cfg = reg_wr_in && (reg_addr_in == CRCSP_ADDR_S3_CFG);

  // scratch A storage.
  // Full mask, since every bit is plain scratch storage.
  crcsp_reg16 #(.WRITE_MASK(CRCSP_MASK_FULL)) u_spare_a (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .wr_in(wr_spare_a),
    .wdata_in(reg_wdata_in),
    .value_out(spare_a)
  );

  // upper byte only.
  // The low byte is never stored, so it cannot drift away from zero.
  crcsp_reg16 #(.WRITE_MASK(CRCSP_MASK_SPARE_B)) u_spare_b (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .wr_in(wr_spare_b),
    .wdata_in(reg_wdata_in),
    .value_out(spare_b)
  );

  // scratch C storage.
  // Full mask, since every bit is plain scratch storage.
  crcsp_reg16 #(.WRITE_MASK(CRCSP_MASK_FULL)) u_spare_c (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .wr_in(wr_spare_c),
    .wdata_in(reg_wdata_in),
    .value_out(spare_c)
  );

  // CRC reference storage.
  // The reference is only stored here; the comparison happens outside this bank.
  crcsp_reg16 #(.WRITE_MASK(CRCSP_MASK_FULL)) u_s2_ref (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .wr_in(wr_s2_ref),
    .wdata_in(reg_wdata_in),
    .value_out(s2_ref)
  );

  // reserved bits masked.
  // Only the enable bit and the level field are stored; bits 14 to 3 stay zero.
  crcsp_reg16 #(.WRITE_MASK(CRCSP_MASK_S3_CFG)) u_s3_cfg (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .wr_in(wr_s3_cfg),
    .wdata_in(reg_wdata_in),
    .value_out(s3_cfg)
  );

  // The level field seen as its enumerated code.
  assign tdac_code = crcsp_tdac_type'(s3_cfg[CRCSP_TDAC_MSB:CRCSP_TDAC_LSB]);

  // Read mux; the masks inside each register already force reserved bits to zero.
  always_comb begin
    next_rdata = CRCSP_RESET_VALUE;
    next_hit = 1'b1;
    unique case (reg_addr_in)
      CRCSP_ADDR_SPARE_A: next_rdata = spare_a;
      CRCSP_ADDR_SPARE_B: next_rdata = spare_b;
      CRCSP_ADDR_SPARE_C: next_rdata = spare_c;
      CRCSP_ADDR_S2_REF: next_rdata = s2_ref;
      CRCSP_ADDR_S3_CFG: next_rdata = s3_cfg;
      default: next_hit = 1'b0;
    endcase
  end

  // Read valid is a one-cycle pulse that follows the strobe of the edge before.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // Read data and hit flag hold until the next read, so a slow host may take them late.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= CRCSP_RESET_VALUE;
      reg_hit_out <= 1'b0;
    end else if (clk_en_in && reg_rd_in) begin
      reg_rdata_out <= next_rdata;
      reg_hit_out <= next_hit;
    end
  end

  // spare contents exported only for the CRC.
  // Spares drive nothing else, so their values cannot disturb any function.
  // The copies lag storage by one cycle, which the CRC engine must allow for.
  // The reference rides along so both CRC inputs share the same lag.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      spare_scratch_a_out <= CRCSP_RESET_VALUE;
      spare_scratch_b_out <= CRCSP_RESET_VALUE;
      spare_scratch_c_out <= CRCSP_RESET_VALUE;
      section2_crc_reference_value_out <= CRCSP_RESET_VALUE;
    end else if (clk_en_in) begin
      spare_scratch_a_out <= spare_a;
      spare_scratch_b_out <= spare_b;
      spare_scratch_c_out <= spare_c;
      section2_crc_reference_value_out <= s2_ref;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      section3_crc_enable_out <= 1'b0;
    end else if (clk_en_in) begin
      section3_crc_enable_out <= s3_cfg[CRCSP_S3_EN_BIT];
    end
  end

  // sign of level.
  // Only the two negative codes flip the sign. The unconfirmed codes 3 and 5
  // are treated as positive until their meaning is settled.
  always_comb begin
    next_dac_negative = 1'b0;
    unique case (tdac_code)
      CRCSP_TDAC_X1, CRCSP_TDAC_X2, CRCSP_TDAC_X4, CRCSP_TDAC_U3: next_dac_negative = 1'b0;
      CRCSP_TDAC_X18, CRCSP_TDAC_U5: next_dac_negative = 1'b0;
      CRCSP_TDAC_NEG4, CRCSP_TDAC_NEG9: next_dac_negative = 1'b1;
    endcase
  end

  // DAC level output.
  // Codes 3 and 5 are unconfirmed; they pass through unchanged.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      test_dac_b_level_out <= 3'h0;
      test_dac_b_negative_out <= 1'b0;
    end else if (clk_en_in) begin
      test_dac_b_level_out <= tdac_code;
      test_dac_b_negative_out <= next_dac_negative;
    end
  end

endmodule : crcsp_regs

// [crcsp_regs_monitor.sv]
// Checker for the spare, CRC reference and test DAC B register bank.
// Assumes it is bound to crcsp_regs and sees only its ports.
`timescale 1ns/1ps
module crcsp_regs_monitor (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic reg_hit_out,
  input wire logic [15:0] spare_scratch_b_out,
  input wire logic section3_crc_enable_out,
  input wire logic [2:0] test_dac_b_level_out,
  input wire logic test_dac_b_negative_out
);
  // One clock domain, so one clock and one reset serve every check.
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic rd;
  logic wr;
  // A strobe only counts while the clock enable is high.
  assign rd = reg_rd_in && clk_en_in;
  assign wr = reg_wr_in && clk_en_in;
  property p_rvalid; rd |=> reg_rvalid_out; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid missing");
  property p_quiet; clk_en_in && !reg_rd_in |=> !reg_rvalid_out && $stable(reg_rdata_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data moved");
  // A low clock enable must leave read valid, read data and the spare B copy where they were.
  property p_freeze; !clk_en_in |=> $stable(reg_rvalid_out) && $stable(reg_rdata_out) &&
    $stable(spare_scratch_b_out); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_rd_b; rd && reg_addr_in == 8'ha2 |=> reg_hit_out && reg_rdata_out[7:0] == 8'h00;
  endproperty
  a_rd_b: assert property (p_rd_b) else $error("low byte of a2 not zero");
  property p_rd_c0; rd && reg_addr_in == 8'hc0 |=> reg_rdata_out[14:3] == 12'h000; endproperty
  a_rd_c0: assert property (p_rd_c0) else $error("reserved c0 bits not zero");
  property p_miss; rd && reg_addr_in == 8'ha4 |=> !reg_hit_out && reg_rdata_out == 16'h0000;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped read not zero");
  property p_en; (wr && reg_addr_in == 8'hc0) ##1 clk_en_in |=>
    section3_crc_enable_out == $past(reg_wdata_in[15], 2); endproperty
  a_en: assert property (p_en) else $error("section 3 enable wrong");
  property p_lvl; (wr && reg_addr_in == 8'hc0) ##1 clk_en_in |=>
    test_dac_b_level_out == $past(reg_wdata_in[2:0], 2); endproperty
  a_lvl: assert property (p_lvl) else $error("test dac level wrong");
  property p_neg; test_dac_b_negative_out == (test_dac_b_level_out[2:1] == 2'b11); endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_b; (wr && reg_addr_in == 8'ha2) ##1 clk_en_in |=>
    spare_scratch_b_out == {$past(reg_wdata_in[15:8], 2), 8'h00}; endproperty
  a_b: assert property (p_b) else $error("spare b wrong");
endmodule : crcsp_regs_monitor
bind crcsp_regs crcsp_regs_monitor u_mon (.ref_clk_in, .rst_in, .clk_en_in, .reg_addr_in,
  .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .reg_hit_out,
  .spare_scratch_b_out, .section3_crc_enable_out, .test_dac_b_level_out,
  .test_dac_b_negative_out);

// [crcsp_regs_tb.sv]
// Testbench for crcsp_regs: register reads and writes against expected values.
// Assumes one-cycle strobes with read data one edge later.
`timescale 1ns/1ps
module crcsp_regs_tb;
  import crcsp_pkg::*;
  logic ref_clk_in = 0, rst_in = 1, clk_en_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, sa, sb, sc, s2, v;
  logic reg_rvalid_out, reg_hit_out, en, neg;
  logic [2:0] lvl;
  int fail_count = 0, cmp_count = 0;
  logic [7:0] ad [5] = '{8'ha1, 8'ha2, 8'ha3, 8'hbe, 8'hc0};
  logic [15:0] mk [5] = '{16'hffff, 16'hff00, 16'hffff, 16'hffff, 16'h8007};
  crcsp_regs dut (.ref_clk_in, .rst_in, .clk_en_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .reg_hit_out, .spare_scratch_a_out(sa),
    .spare_scratch_b_out(sb), .spare_scratch_c_out(sc), .section2_crc_reference_value_out(s2),
    .section3_crc_enable_out(en), .test_dac_b_level_out(lvl), .test_dac_b_negative_out(neg));
  // Period of 100 ns.
  always #50 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  // Reads one word into v and checks the valid pulse and the hit flag.
  task automatic rd(input logic [7:0] a, input logic h);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    v = reg_rdata_out;
    chk({14'h0, reg_rvalid_out, reg_hit_out}, {14'h0, 1'b1, h});
  endtask : rd
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  // Each test is a series of bus calls, so no wait can hang.
  initial begin
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    foreach (ad[i]) begin
      rd(ad[i], 1'b1);
      chk(v, 16'h0000);
    end
    $display("reset test done");
    foreach (ad[i]) wr(ad[i], 16'hffff);
    foreach (ad[i]) begin
      rd(ad[i], 1'b1);
      chk(v, mk[i]);
    end
    chk(sb, 16'hff00);
    chk(sc & s2, 16'hffff);
    chk({12'h0, en, lvl}, 16'h000f);
    $display("mask test done");
    for (int i = 0; i < 8; i++) begin
      wr(8'hc0, 16'h7ff8 | 16'(i));
      rd(8'hc0, 1'b1);
      chk(v, 16'(i));
      chk({12'h0, neg, lvl}, {12'h0, i > 5, 3'(i)});
      chk({15'h0, en}, 16'h0000);
    end
    chk(sa, 16'hffff);
    $display("code test done");
    clk_en_in = 1'b0;
    wr(8'ha3, 16'h1234);
    clk_en_in = 1'b1;
    wr(8'ha4, 16'h5a5a);
    rd(8'ha3, 1'b1);
    chk(v, 16'hffff);
    rd(8'ha4, 1'b0);
    chk(v, 16'h0000);
    $display("refusal test done");
    rst_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    rst_in = 1'b0;
    chk(sa | sb | sc | s2 | reg_rdata_out, 16'h0000);
    chk({9'h0, en, neg, lvl, reg_rvalid_out, reg_hit_out}, 16'h0000);
    foreach (ad[i]) begin
      rd(ad[i], 1'b1);
      chk(v, 16'h0000);
    end
    $display("second reset test done");
    end_sim();
  end
endmodule : crcsp_regs_tb
